// ==== adc_cal_params.svh ====
// Constants for the converter calibration control block
//
// Overview of operation
// (RULE1) Software finishes an offset calibration before starting a gain one.
// (RULE2) Offset calibration stores one measurement's deviation from zero.
// (RULE3) Stored offset is subtracted from every conversion result.
// (RULE4) Gain calibration uses one full-scale sample and the stored offset.
// (RULE5) Offset-corrected results are multiplied by the stored gain factor.
// (RULE6) Writing a calibration code into the mode field starts it.
// (RULE7) Busy flag is one for the whole calibration.
// (RULE8) On completion: mode idle, busy cleared, complete set, interrupt.
// (RULE9) Computed coefficient is written into its coefficient registers.
// (RULE10) Internal calibration offers offset only, gain only and full.
// (RULE11) Full internal calibration runs offset then gain from one write.
// (RULE12) Internal offset calibration switches inputs to analog ground.
// (RULE13) Internal gain calibration switches inputs to reference over gain.
// (RULE14) System offset and gain calibrations measure the external inputs.
// (RULE15) Outside party holds inputs at zero during system offset.
// (RULE16) Outside party applies positive full scale during system gain.
// (RULE17) Both 24-bit coefficients are readable and writable by software.
// (RULE18) Offset is signed two's complement over high, middle, low bytes.
// (RULE19) Offset result of 0x7fffff or 0x800000 flags an error.
// (RULE20) Gain is unsigned fixed point, top bit one, LSB two to minus 23.
// (RULE21) Gain result of zero or maximum flags an error.
// (RULE22) Error flag also set when a result exceeds coefficient limits.
// (RULE23) Converter disable resets mode to idle, keeps all other settings.
// (RULE24) Each calibration variant has its own distinct mode code.
`ifndef ADC_CAL_PARAMS_SVH
`define ADC_CAL_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h01
`define ADDR_OFS_HIGH 8'h02
`define ADDR_OFS_MID 8'h03
`define ADDR_OFS_LOW 8'h04
`define ADDR_GAIN_HIGH 8'h05
`define ADDR_GAIN_MID 8'h06
`define ADDR_GAIN_LOW 8'h07

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CTRL_EN_BIT 7
`define ST_BUSY_BIT 0
`define ST_CALC_BIT 1
`define ST_ERR_BIT 2

// ------------------------------------------------------------
// Mode field codes
// ------------------------------------------------------------
`define MODE_IDLE 3'h0
`define MODE_INT_FULL 3'h3
`define MODE_INT_OFS 3'h4
`define MODE_INT_GAIN 3'h5
`define MODE_SYS_OFS 3'h6
`define MODE_SYS_GAIN 3'h7

// ------------------------------------------------------------
// Input source selections
// ------------------------------------------------------------
`define SEL_EXTERNAL 2'h0
`define SEL_ANALOG_GROUND 2'h1
`define SEL_FULL_SCALE 2'h2

// ------------------------------------------------------------
// Reset values, limits and counts
// ------------------------------------------------------------
`define OFS_RESET 24'h000000
`define GAIN_RESET 24'h800000
`define OFS_POS_FS 24'h7fffff
`define OFS_NEG_FS 24'h800000
`define GAIN_ZERO 24'h000000
`define GAIN_MAX 24'hffffff
`define DIV_STEPS 5'd24
`define DIV_REM_INIT 26'h0400000

`endif

// ==== adc_cal_pkg.sv ====
// Types shared by the converter calibration control block
package adc_cal_pkg;

  // Calibration sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_OFS_MEAS, ST_GAIN_MEAS, ST_GAIN_DIV, ST_DONE
  } cal_state_type;

  // One converter sample with its strobe
  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } sample_type;

  // Status flags as seen by software
  typedef struct packed {
    logic err;
    logic calc;
    logic busy;
  } status_type;

endpackage

// ==== adc_calibration_control.sv ====
// Calibration sequencer, coefficient store and result correction
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "adc_cal_params.svh"

module adc_calibration_control
  import adc_cal_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock, reset and clock enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Raw modulator samples, same clock
  input wire sample_type raw_sample,
  // Corrected conversion results
  output sample_type corr_sample,
  // Analog input source selection
  output logic [1:0] input_sel,
  // Status and calibration-done interrupt pulse
  output status_type status,
  output logic cal_irq
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (ADDR_W < 3) begin : g_bad_addr
    $error("ADDR_W too narrow for the register map");
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Match a bus address against a byte offset
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] off);
    addr_is = (a == ADDR_W'(off));
  endfunction

  // Clamp a wide signed value to the 24-bit signed range
  function automatic logic [23:0] sat24(input logic signed [26:0] v);
    if (v > 27'sh07fffff) begin
      sat24 = `OFS_POS_FS;
    end else if (v < -27'sh0800000) begin
      sat24 = `OFS_NEG_FS;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  cal_state_type state_q;
  logic conv_en_q;
  logic [2:0] mode_q;
  logic full_q;
  logic busy_q;
  logic calc_q;
  logic err_q;
  logic [23:0] ofs_q;
  logic [23:0] gain_q;
  logic [25:0] div_rem_q;
  logic [25:0] div_den_q;
  logic [23:0] div_quo_q;
  logic [4:0] div_cnt_q;
  logic [1:0] sel_q;
  logic irq_q;
  logic [7:0] rdata_q;
  logic signed [24:0] diff_q;
  logic diff_vld_q;
  sample_type corr_q;

  // Decoded bus writes, sequencer events and divider values
  logic wr_ctrl;
  logic wr_status;
  logic start_cal;
  logic mode_is_cal;
  logic done_evt;
  logic ofs_hw_wr;
  logic gain_hw_wr;
  logic ofs_err;
  logic gain_err;
  logic [23:0] gain_res;
  logic signed [24:0] gain_den;
  logic [25:0] div_shift;

  assign wr_ctrl = reg_wr && addr_is(reg_addr, `ADDR_CTRL);
  assign wr_status = reg_wr && addr_is(reg_addr, `ADDR_STATUS);

  // Any one of the five calibration codes
  always_comb begin
    case (reg_wdata[2:0])
      `MODE_INT_FULL, `MODE_INT_OFS, `MODE_INT_GAIN,
      `MODE_SYS_OFS, `MODE_SYS_GAIN: mode_is_cal = 1'b1; // RULE24
      default: mode_is_cal = 1'b0;
    endcase
  end

  // Start only when enabled, idle and a calibration code is written
  assign start_cal = wr_ctrl && reg_wdata[`CTRL_EN_BIT] && conv_en_q &&
                     mode_is_cal && (state_q == ST_IDLE); // RULE6

  // ------------------------------------------------------------
  // Calibration sequencer
  // ------------------------------------------------------------
  // Denominator of the gain factor: full-scale sample minus zero point
  assign gain_den = $signed({raw_sample.data[23], raw_sample.data}) -
                    $signed({ofs_q[23], ofs_q}); // RULE4 RULE1
  assign div_shift = {div_rem_q[24:0], 1'b0};

  // Sequence offset and gain phases, abort when the converter is disabled
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      full_q <= 1'b0;
      div_rem_q <= 26'h0000000;
      div_den_q <= 26'h0000000;
      div_quo_q <= 24'h000000;
      div_cnt_q <= 5'd0;
      gain_res <= `GAIN_RESET;
    end else if (clk_en) begin
      if (!conv_en_q) begin
        state_q <= ST_IDLE; // RULE23
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (start_cal) begin
              full_q <= (reg_wdata[2:0] == `MODE_INT_FULL); // RULE11
              case (reg_wdata[2:0])
                `MODE_INT_GAIN, `MODE_SYS_GAIN: state_q <= ST_GAIN_MEAS;
                default: state_q <= ST_OFS_MEAS; // RULE10 RULE14
              endcase
            end
          end
          ST_OFS_MEAS: begin
            if (raw_sample.valid) begin
              state_q <= full_q ? ST_GAIN_MEAS : ST_DONE; // RULE11
            end
          end
          ST_GAIN_MEAS: begin
            if (raw_sample.valid) begin
              if (gain_den <= 25'sh0400000) begin
                // Result would not fit: clamp at the top of the range
                gain_res <= `GAIN_MAX; // RULE22
                state_q <= ST_DONE;
              end else begin
                div_rem_q <= `DIV_REM_INIT;
                div_den_q <= {1'b0, gain_den};
                div_quo_q <= 24'h000000;
                div_cnt_q <= `DIV_STEPS;
                state_q <= ST_GAIN_DIV;
              end
            end
          end
          ST_GAIN_DIV: begin
            // One quotient bit a cycle of two to the 46 over the span
            if (div_shift >= div_den_q) begin
              div_rem_q <= div_shift - div_den_q;
              div_quo_q <= {div_quo_q[22:0], 1'b1};
            end else begin
              div_rem_q <= div_shift;
              div_quo_q <= {div_quo_q[22:0], 1'b0};
            end
            div_cnt_q <= div_cnt_q - 5'd1;
            if (div_cnt_q == 5'd1) begin
              state_q <= ST_DONE;
            end
          end
          ST_DONE: begin
            state_q <= ST_IDLE;
          end
          default: state_q <= ST_IDLE;
        endcase
        if (state_q == ST_GAIN_DIV && div_cnt_q == 5'd1) begin
          gain_res <= (div_shift >= div_den_q) ?
                      {div_quo_q[22:0], 1'b1} : {div_quo_q[22:0], 1'b0};
        end
      end
    end
  end

  // Hardware coefficient writes and their error checks
  assign ofs_hw_wr = (state_q == ST_OFS_MEAS) && raw_sample.valid &&
                     conv_en_q;
  assign ofs_err = ofs_hw_wr && (raw_sample.data == `OFS_POS_FS ||
                   raw_sample.data == `OFS_NEG_FS); // RULE19
  assign gain_hw_wr = (state_q == ST_DONE) && conv_en_q &&
                      (mode_q == `MODE_INT_GAIN ||
                       mode_q == `MODE_SYS_GAIN || full_q);
  assign gain_err = gain_hw_wr && (gain_res == `GAIN_ZERO ||
                    gain_res == `GAIN_MAX); // RULE21 RULE22
  assign done_evt = (state_q == ST_DONE) && conv_en_q;

  // ------------------------------------------------------------
  // Control register: enable and mode field
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      conv_en_q <= 1'b0;
      mode_q <= `MODE_IDLE;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        conv_en_q <= reg_wdata[`CTRL_EN_BIT];
      end
      if (!conv_en_q || (wr_ctrl && !reg_wdata[`CTRL_EN_BIT])) begin
        mode_q <= `MODE_IDLE; // RULE23
      end else if (done_evt) begin
        mode_q <= `MODE_IDLE; // RULE8
      end else if (wr_ctrl && (state_q == ST_IDLE)) begin
        mode_q <= reg_wdata[2:0]; // RULE6
      end
    end
  end

  // ------------------------------------------------------------
  // Status flags; hardware set wins over a software clear
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      calc_q <= 1'b0;
      err_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      if (start_cal) begin
        busy_q <= 1'b1; // RULE7
      end else if (done_evt || !conv_en_q) begin
        busy_q <= 1'b0; // RULE8
      end
      if (done_evt) begin
        calc_q <= 1'b1; // RULE8
      end else if (wr_status && reg_wdata[`ST_CALC_BIT]) begin
        calc_q <= 1'b0;
      end
      if (ofs_err || gain_err) begin
        err_q <= 1'b1; // RULE22
      end else if (wr_status && reg_wdata[`ST_ERR_BIT]) begin
        err_q <= 1'b0;
      end
      irq_q <= done_evt; // RULE8
    end
  end

  // ------------------------------------------------------------
  // Coefficient registers
  // ------------------------------------------------------------
  // Offset: signed, software bytes, hardware result wins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ofs_q <= `OFS_RESET;
    end else if (clk_en) begin
      if (ofs_hw_wr) begin
        ofs_q <= raw_sample.data; // RULE2 RULE9 RULE18
      end else if (reg_wr) begin
        if (addr_is(reg_addr, `ADDR_OFS_HIGH)) begin
          ofs_q[23:16] <= reg_wdata; // RULE17
        end
        if (addr_is(reg_addr, `ADDR_OFS_MID)) begin
          ofs_q[15:8] <= reg_wdata; // RULE17
        end
        if (addr_is(reg_addr, `ADDR_OFS_LOW)) begin
          ofs_q[7:0] <= reg_wdata; // RULE17
        end
      end
    end
  end

  // Gain: unsigned 1.23 fixed point, hardware result wins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gain_q <= `GAIN_RESET;
    end else if (clk_en) begin
      if (gain_hw_wr) begin
        gain_q <= gain_res; // RULE9 RULE20
      end else if (reg_wr) begin
        if (addr_is(reg_addr, `ADDR_GAIN_HIGH)) begin
          gain_q[23:16] <= reg_wdata; // RULE17
        end
        if (addr_is(reg_addr, `ADDR_GAIN_MID)) begin
          gain_q[15:8] <= reg_wdata; // RULE17
        end
        if (addr_is(reg_addr, `ADDR_GAIN_LOW)) begin
          gain_q[7:0] <= reg_wdata; // RULE17
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Input source selection
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sel_q <= `SEL_EXTERNAL;
    end else if (clk_en) begin
      if (!conv_en_q || state_q == ST_DONE || state_q == ST_IDLE) begin
        sel_q <= `SEL_EXTERNAL;
      end
      if (start_cal) begin
        case (reg_wdata[2:0])
          `MODE_INT_FULL, `MODE_INT_OFS: sel_q <= `SEL_ANALOG_GROUND; // RULE12
          `MODE_INT_GAIN: sel_q <= `SEL_FULL_SCALE; // RULE13
          default: sel_q <= `SEL_EXTERNAL; // RULE14
        endcase
      end else if (ofs_hw_wr && full_q) begin
        sel_q <= `SEL_FULL_SCALE; // RULE13
      end
    end
  end

  // ------------------------------------------------------------
  // Result correction pipeline
  // ------------------------------------------------------------
  // Stage one: remove the zero point; calibration samples are not results
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      diff_q <= 25'sh0000000;
      diff_vld_q <= 1'b0;
    end else if (clk_en) begin
      diff_vld_q <= raw_sample.valid && conv_en_q && !busy_q;
      diff_q <= $signed({raw_sample.data[23], raw_sample.data}) -
                $signed({ofs_q[23], ofs_q}); // RULE3
    end
  end

  // Stage two: scale by the gain factor and clamp to 24 bits
  logic signed [49:0] prod;
  assign prod = diff_q * $signed({1'b0, gain_q}); // RULE5 RULE20

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      corr_q <= '0;
    end else if (clk_en) begin
      corr_q.valid <= diff_vld_q;
      corr_q.data <= sat24(prod[49:23]); // RULE5
    end
  end

  // ------------------------------------------------------------
  // Register read port, data in the cycle after the strobe only
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= 8'h00;
      if (reg_rd) begin
        if (addr_is(reg_addr, `ADDR_CTRL)) begin
          rdata_q <= {conv_en_q, 4'h0, mode_q};
        end
        if (addr_is(reg_addr, `ADDR_STATUS)) begin
          rdata_q <= {5'h00, err_q, calc_q, busy_q};
        end
        if (addr_is(reg_addr, `ADDR_OFS_HIGH)) begin
          rdata_q <= ofs_q[23:16];
        end
        if (addr_is(reg_addr, `ADDR_OFS_MID)) begin
          rdata_q <= ofs_q[15:8];
        end
        if (addr_is(reg_addr, `ADDR_OFS_LOW)) begin
          rdata_q <= ofs_q[7:0];
        end
        if (addr_is(reg_addr, `ADDR_GAIN_HIGH)) begin
          rdata_q <= gain_q[23:16];
        end
        if (addr_is(reg_addr, `ADDR_GAIN_MID)) begin
          rdata_q <= gain_q[15:8];
        end
        if (addr_is(reg_addr, `ADDR_GAIN_LOW)) begin
          rdata_q <= gain_q[7:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ------------------------------------------------------------
  assign reg_rdata = rdata_q;
  assign corr_sample = corr_q;
  assign input_sel = sel_q;
  assign status = '{err: err_q, calc: calc_q, busy: busy_q};
  assign cal_irq = irq_q;

endmodule

// ==== adc_cal_props.sv ====
// Concurrent checks on the ports of the calibration control block
`timescale 1ns/100ps
`include "adc_cal_params.svh"

module adc_cal_props
  import adc_cal_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Samples, source selection and status
  input wire sample_type raw_sample,
  input wire sample_type corr_sample,
  input wire logic [1:0] input_sel,
  input wire status_type status,
  input wire logic cal_irq
);

  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic en_q;

  // Follows the converter enable bit as software writes it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      en_q <= 1'b0;
    end else if (clk_en && reg_wr && reg_addr == `ADDR_CTRL) begin
      en_q <= reg_wdata[`CTRL_EN_BIT];
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // Sequences and assertions
  // ----------------------------------------
  sequence s_start;
    clk_en && reg_wr && reg_addr == `ADDR_CTRL && reg_wdata[7] && en_q &&
      reg_wdata[2:0] >= 3'h3 && !status.busy;
  endsequence

  sequence s_done;
    !status.busy && status.calc;
  endsequence

  a_start_busy: assert property (s_start |=> status.busy)
    else $error("calibration did not start");
  a_done_flags: assert property (cal_irq |-> s_done)
    else $error("completion flags wrong");
  a_irq_pulse: assert property (cal_irq |=> !cal_irq)
    else $error("interrupt longer than one cycle");
  a_busy_fall: assert property ($fell(status.busy) |-> cal_irq || !en_q)
    else $error("busy dropped early");
  a_sel_idle: assert property (!status.busy |-> input_sel == 2'h0)
    else $error("input switched outside calibration");
  a_ofs_step: assert property (status.busy &&
    input_sel == `SEL_ANALOG_GROUND && raw_sample.valid |->
    ##[1:2] (cal_irq || input_sel == `SEL_FULL_SCALE))
    else $error("offset step did not finish");
  a_gain_time: assert property (status.busy &&
    input_sel == `SEL_FULL_SCALE && raw_sample.valid |-> ##[1:26] cal_irq)
    else $error("gain step did not finish");
  a_corr_lat: assert property (raw_sample.valid &&
    !status.busy && en_q && clk_en |-> ##2 corr_sample.valid)
    else $error("no corrected result");
  a_corr_src: assert property (corr_sample.valid |->
    $past(raw_sample.valid, 2)) else $error("stray result");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");

endmodule

// ==== adc_calibration_control_tb.sv ====
// Self-checking bench for the calibration control block
`timescale 1ns/100ps
`include "adc_cal_params.svh"

module adc_calibration_control_tb
  import adc_cal_pkg::*;
;

  // ----------------------------------------
  // Signals and tables
  // ----------------------------------------
  logic mclk, sys_rst, clk_en, reg_wr, reg_rd, cal_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] input_sel;
  sample_type raw_sample, corr_sample;
  status_type status;
  int errors = 0;
  int n_tests = 0;
  // Reset values of addresses 0 to 7
  localparam logic [63:0] RST_V = 64'h0000000000800000;
  // Address, write data, read back
  localparam logic [23:0] REG_ROWS [8] = '{24'h02a5a5, 24'h035a5a,
    24'h040101, 24'h05c3c3, 24'h063c3c, 24'h07ffff, 24'h207700, 24'h01ff00};
  // Gain, raw sample, corrected result with offset 0x000123
  localparam logic [71:0] CONV_ROWS [5] = '{
    72'h800000_000200_0000dd, 72'h400000_000200_00006e,
    72'h400000_000000_ffff6e, 72'hffffff_7fffff_7fffff,
    72'hffffff_800000_800000};

  adc_calibration_control #(.ADDR_W(8)) adc_calibration_control_i (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_sample(raw_sample),
    .corr_sample(corr_sample), .input_sel(input_sel), .status(status),
    .cal_irq(cal_irq));

  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check("rdata", {24'h0, reg_rdata}, {24'h0, e});
  endtask

  // Six byte writes or reads: offset high to low, then gain
  task automatic set_coef(logic [23:0] o, logic [23:0] g);
    logic [47:0] v;
    v = {o, g};
    for (int i = 0; i < 6; i++) begin
      wr(8'(`ADDR_OFS_HIGH + i), v[47-8*i -: 8]);
    end
  endtask

  task automatic chk_coef(logic [23:0] o, logic [23:0] g);
    logic [47:0] v;
    v = {o, g};
    for (int i = 0; i < 6; i++) begin
      rd(8'(`ADDR_OFS_HIGH + i), v[47-8*i -: 8]);
    end
  endtask

  task automatic smp(logic [23:0] d);
    @(posedge mclk);
    raw_sample <= '{valid: 1'b1, data: d};
    @(posedge mclk);
    raw_sample <= '{valid: 1'b0, data: ~d};
    #1;
  endtask

  // Waits for the completion pulse; exp of zero skips the cycle count
  task automatic wait_irq(int exp);
    int n = 0;
    while (cal_irq !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 100) begin
        check("timeout", 1, 0);
        finish_test();
      end
    end
    if (exp > 0) begin
      check("irq_wait", n, exp);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    raw_sample = '0;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(8'(i), RST_V[63-8*i -: 8]);
    end
    // Register rows, unmapped and read-only places among them
    for (int i = 0; i < 8; i++) begin
      wr(REG_ROWS[i][23:16], REG_ROWS[i][15:8]);
      rd(REG_ROWS[i][23:16], REG_ROWS[i][7:0]);
    end
    // Codes are refused while disabled, then internal offset only
    set_coef(24'h000000, 24'h800000);
    wr(`ADDR_CTRL, 8'h84);
    check("busy", status.busy, 1'b0);
    wr(`ADDR_CTRL, 8'h80);
    wr(`ADDR_CTRL, 8'h84);
    check("busy", status.busy, 1'b1);
    check("sel", input_sel, `SEL_ANALOG_GROUND);
    rd(`ADDR_CTRL, 8'h84);
    smp(24'h000123);
    wait_irq(1);
    check("status", status, 3'h2);
    rd(`ADDR_CTRL, 8'h80);
    chk_coef(24'h000123, 24'h800000);
    // Conversion rows through offset and gain correction
    for (int i = 0; i < 5; i++) begin
      set_coef(24'h000123, CONV_ROWS[i][71:48]);
      smp(CONV_ROWS[i][47:24]);
      @(posedge mclk);
      #1;
      check("corr_valid", corr_sample.valid, 1'b1);
      check("corr_data", corr_sample.data, CONV_ROWS[i][23:0]);
    end
    // Internal gain after the offset, span 0x600000
    set_coef(24'h000123, 24'h800000);
    wr(`ADDR_CTRL, 8'h85);
    check("sel", input_sel, `SEL_FULL_SCALE);
    smp(24'h600123);
    wait_irq(25);
    chk_coef(24'h000123, 24'haaaaaa);
    check("status", status, 3'h2);
    wr(`ADDR_STATUS, 8'h06);
    check("status", status, 3'h0);
    // Full internal from one write, gain span at the clamp limit
    wr(`ADDR_CTRL, 8'h83);
    check("sel", input_sel, `SEL_ANALOG_GROUND);
    smp(24'h000040);
    @(posedge mclk);
    #1;
    check("sel", input_sel, `SEL_FULL_SCALE);
    smp(24'h400040);
    wait_irq(0);
    check("status", status, 3'h6);
    chk_coef(24'h000040, 24'hffffff);
    // System offset at both signed extremes
    for (int i = 0; i < 2; i++) begin
      wr(`ADDR_STATUS, 8'h06);
      wr(`ADDR_CTRL, 8'h86);
      check("sel", input_sel, `SEL_EXTERNAL);
      smp(i == 0 ? 24'h7fffff : 24'h800000);
      wait_irq(1);
      check("status", status, 3'h6);
    end
    // System gain aborted by disable before any input is applied
    wr(`ADDR_CTRL, 8'h87);
    check("busy", status.busy, 1'b1);
    wr(`ADDR_CTRL, 8'h00);
    // Busy drops one cycle after the disabling write is taken
    @(posedge mclk);
    #1;
    check("busy", status.busy, 1'b0);
    rd(`ADDR_CTRL, 8'h00);
    chk_coef(24'h800000, 24'hffffff);
    // Clock enable low: a byte write is not taken
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(`ADDR_OFS_LOW, 8'h55);
    @(posedge mclk);
    clk_en <= 1'b1;
    rd(`ADDR_OFS_LOW, 8'h00);
    // Reset while disabled and idle clears flags and coefficients
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    check("status", status, 3'h0);
    check("sel", input_sel, `SEL_EXTERNAL);
    check("irq", cal_irq, 1'b0);
    check("corr_valid", corr_sample.valid, 1'b0);
    rd(`ADDR_CTRL, 8'h00);
    chk_coef(24'h000000, 24'h800000);
    finish_test();
  end

endmodule

bind adc_calibration_control adc_cal_props #(.ADDR_W(ADDR_W)) adc_cal_props_i (
  .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .raw_sample(raw_sample),
  .corr_sample(corr_sample), .input_sel(input_sel), .status(status),
  .cal_irq(cal_irq));
